// >>> swdt_pkg.sv
// Package of constants for the supervisor watchdog timer
package swdt_pkg;
    // Internal time base nominal rate in Hz
    localparam int INT_OSC_HZ      = 10240;
    // Main clock rate in Hz
    localparam int MCLK_HZ         = 20000000;
    // Main clocks per internal time base tick
    localparam int TICK_DIV        = MCLK_HZ / INT_OSC_HZ;
    // Counter widths
    localparam int CNT_W           = 16;
    localparam int DIV_W           = 12;
    // Timebase clock counts
    localparam logic [15:0] NORM_CLKS       = 16'h0400;
    localparam logic [15:0] LONG_CLKS       = 16'h1000;
    localparam logic [15:0] RST_SHORT_CLKS  = 16'h0200;
    localparam logic [15:0] RST_LONG_CLKS   = 16'h0800;
    // Internal mode short normal period (100 ms at 10.24 kHz)
    localparam logic [15:0] INT_SHORT_CLKS  = 16'h0400;
    // Internal mode long period (1.6 s at 10.24 kHz)
    localparam logic [15:0] INT_LONG_CLKS   = 16'h4000;
    // Documented times, milliseconds
    localparam int RST_SHORT_MS    = 35;
    localparam int RST_LONG_MS     = 140;
    localparam int MIN_LONG_MS     = 1000;
    // Divider reset value
    localparam logic [11:0] DIV_RST = 12'h000;
    // Watchdog phase
    typedef enum logic [1:0] {SWDT_LONG, SWDT_NORMAL, SWDT_RESET} swdt_phase_e;
endpackage

// >>> swdt_edge.sv
// Two-stage synchroniser with both-edge detector for the kick input
`timescale 1ns/10ps
module swdt_edge
(
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    input  wire logic i_din,
    output logic      o_edge
);
    logic s1;       // First sync stage
    logic s2;       // Second sync stage
    logic s3;       // Previous synced value
    logic next_s1;
    logic next_s2;
    logic next_s3;
    logic next_edge;

    // Next values of the sync chain and edge flag
    always_comb
    begin
        next_s1   = i_din;
        next_s2   = s1;
        next_s3   = s2;
        next_edge = s2 ^ s3;
    end

    // Register the sync chain
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s1     <= 1'b0;
            s2     <= 1'b0;
            s3     <= 1'b0;
            o_edge <= 1'b0;
        end
        else
        begin
            s1     <= next_s1;
            s2     <= next_s2;
            s3     <= next_s3;
            o_edge <= next_edge;
        end
    end
endmodule

// >>> swdt_top.sv
// Supervisor watchdog timer top level
`timescale 1ns/10ps
// Summary of operation
// - Timeout drives reset low 35 or 140ms; code holds it 512 or 2048 ticks, 50 or 200ms internal
// - Adjustable variant: long timeout after reset
// - Normal timeout after first kick edge
// - Fixed variant: long timeout always
// - Count restarts when reset releases
// - Either kick edge clears the count
// - Static kick input repeats reset pulses
// - Floating kick input disables watchdog
// - Supply fail disables the timer
// - Expired output low until next kick
// - Supply fail forces expired output high
// - External clock counts 1024/4096/512/2048; fixed variant times out at 16384
// - Internal mode fixes reset active time
// - Timebase level picks 100ms or 1.6s
// - Internal mode keeps long post-reset period
// - Internal time base 10.24kHz nominal
// - Battery backup ignores inputs, expired high
module swdt_top
#(
    parameter bit ADJUSTABLE = 1'b1,  // Adjustable variant
    parameter bit LONG_PULSE = 1'b0   // 140 ms reset variant; 2048 ticks, 200 ms on the internal base
)
(
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    input  wire logic i_watchdog_kick_in,
    input  wire logic i_kick_floating,
    input  wire logic i_clock_source_select,
    input  wire logic i_sel_floating,
    input  wire logic i_timebase_input,
    input  wire logic i_timebase_floating,
    input  wire logic i_supply_low,
    input  wire logic i_backup_battery_level,
    output logic      o_reset_n,
    output logic      o_watchdog_expired_n
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic                      kick_edge;   // Synced kick edge pulse
    logic                      tb_prev;     // Previous external clock
    logic [swdt_pkg::DIV_W-1:0] div;        // Internal oscillator divider
    logic                      tick;        // One timebase tick
    logic                      int_mode;    // Internal oscillator used
    logic                      disabled;    // Supply fail or backup
    logic [swdt_pkg::CNT_W-1:0] cnt;        // Timebase tick counter
    logic [swdt_pkg::CNT_W-1:0] limit;      // Current phase limit
    logic [swdt_pkg::CNT_W-1:0] rst_len;    // Reset active ticks
    swdt_pkg::swdt_phase_e     state;       // Watchdog phase
    swdt_pkg::swdt_phase_e     next_state;
    logic [swdt_pkg::CNT_W-1:0] next_cnt;
    logic [swdt_pkg::DIV_W-1:0] next_div;
    logic                      next_tb_prev;
    logic                      next_reset_n;
    logic                      next_wdo_n;
    logic                      ext_tick;    // External clock rising edge
    logic                      int_tick;    // Divider wrap

    ////////////////////////////////////////////////////////////////////
    // Kick synchroniser
    swdt_edge u_edge
    (
        .i_mclk (i_mclk),
        .i_rst_b(i_rst_b),
        .i_din  (i_watchdog_kick_in),
        .o_edge (kick_edge)
    );

    ////////////////////////////////////////////////////////////////////
    // Time base selection and tick generation
    always_comb
    begin
        // Select high or floating chooses internal oscillator
        int_mode     = i_clock_source_select | i_sel_floating;
        // Supply fail or backup disables the timer
        disabled     = i_supply_low | i_backup_battery_level;
        // Rising edge of the external clock pin
        ext_tick     = i_timebase_input & ~tb_prev;
        // Divider wrap marks one internal base tick
        int_tick     = (div ==
                        swdt_pkg::DIV_W'(swdt_pkg::TICK_DIV - 1));
        next_tb_prev = i_timebase_input;
        // Divider restarts after each wrap
        next_div     = int_tick ? swdt_pkg::DIV_RST : div + 1'b1;
        // Tick source follows the select pins
        tick         = int_mode ? int_tick : ext_tick;
    end

    // Register divider and external edge history
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            // Divider cleared, external clock history low so a high pin gives a tick
            div     <= swdt_pkg::DIV_RST;
            tb_prev <= 1'b0;
        end
        else
        begin
            div     <= next_div;
            tb_prev <= next_tb_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Phase limits
    always_comb
    begin
        // Reset active length by variant
        if (int_mode)
            // 512 or 2048 ticks of 10.24 kHz give 50 or 200 ms
            rst_len = LONG_PULSE ? swdt_pkg::RST_LONG_CLKS
                                 : swdt_pkg::RST_SHORT_CLKS;
        else
            rst_len = LONG_PULSE ? swdt_pkg::RST_LONG_CLKS
                                 : swdt_pkg::RST_SHORT_CLKS;
        // Timeout for current phase
        if (!ADJUSTABLE)
            // One fixed long period in every phase
            limit = swdt_pkg::INT_LONG_CLKS;
        else if (!int_mode)
            // External base: clock counts by phase
            limit = (state == swdt_pkg::SWDT_NORMAL)
                    ? swdt_pkg::NORM_CLKS : swdt_pkg::LONG_CLKS;
        else if (state == swdt_pkg::SWDT_NORMAL &&
                 !(i_timebase_input | i_timebase_floating))
            // Internal base, short period chosen
            limit = swdt_pkg::INT_SHORT_CLKS;
        else
            // Internal base, long period
            limit = swdt_pkg::INT_LONG_CLKS;
    end

    ////////////////////////////////////////////////////////////////////
    // Watchdog state next values
    always_comb
    begin
        // Hold everything unless a branch below changes it
        next_state   = state;
        next_cnt     = cnt;
        next_reset_n = o_reset_n;
        next_wdo_n   = o_watchdog_expired_n;
        if (disabled || i_kick_floating)
        begin
            // Timer held idle, restart in long phase
            next_state   = swdt_pkg::SWDT_LONG;
            next_cnt     = '0;
            next_reset_n = 1'b1;
            if (disabled)
                next_wdo_n = 1'b1;
            else if (kick_edge)
                next_wdo_n = 1'b1;
        end
        else
        begin
            unique case (state)
                swdt_pkg::SWDT_LONG, swdt_pkg::SWDT_NORMAL:
                begin
                    if (kick_edge)
                    begin
                        // Either edge is a kick
                        next_cnt   = '0;
                        next_wdo_n = 1'b1;
                        if (ADJUSTABLE)
                            next_state = swdt_pkg::SWDT_NORMAL;
                    end
                    else if (tick)
                    begin
                        if (cnt >= limit - 1'b1)
                        begin
                            // Expiry: enter reset pulse
                            next_state   = swdt_pkg::SWDT_RESET;
                            next_cnt     = '0;
                            next_reset_n = 1'b0;
                            next_wdo_n   = 1'b0;
                        end
                        else
                            // Still counting toward the limit
                            next_cnt = cnt + 1'b1;
                    end
                end
                swdt_pkg::SWDT_RESET:
                begin
                    // A kick inside the pulse only clears the flag
                    if (kick_edge)
                        next_wdo_n = 1'b1;
                    if (tick)
                    begin
                        if (cnt >= rst_len - 1'b1)
                        begin
                            // Release reset, restart long timeout
                            next_state   = swdt_pkg::SWDT_LONG;
                            next_cnt     = '0;
                            next_reset_n = 1'b1;
                        end
                        else
                            // Still inside the reset pulse
                            next_cnt = cnt + 1'b1;
                    end
                end
                default:
                    // Unused code: fall back to the long phase
                    next_state = swdt_pkg::SWDT_LONG;
            endcase
        end
    end

    // Register watchdog state and outputs
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            // Idle: long phase, both outputs released
            state                <= swdt_pkg::SWDT_LONG;
            cnt                  <= '0;
            o_reset_n            <= 1'b1;
            o_watchdog_expired_n <= 1'b1;
        end
        else
        begin
            state                <= next_state;
            cnt                  <= next_cnt;
            o_reset_n            <= next_reset_n;
            o_watchdog_expired_n <= next_wdo_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    // Checks run only while out of reset
    a_reset_low_pulse: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        $fell(o_reset_n) |-> !o_reset_n [*8])
        else $error("reset pulse too short");

    a_reset_wdo_low: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        $fell(o_reset_n) |-> !o_watchdog_expired_n)
        else $error("expired output not low at timeout");

    a_release_restart: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        $rose(o_reset_n) && !disabled |-> cnt == '0)
        else $error("count not restarted at release");

    a_kick_clears: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        kick_edge && !disabled && !i_kick_floating &&
        state != swdt_pkg::SWDT_RESET |=> cnt == '0)
        else $error("kick did not clear count");

    a_disable_quiet: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        disabled |=> o_reset_n && o_watchdog_expired_n)
        else $error("disabled timer still active");

    a_float_quiet: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        i_kick_floating ##1 i_kick_floating |-> o_reset_n)
        else $error("floating kick still resets");

    a_first_kick_normal: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        state == swdt_pkg::SWDT_LONG && kick_edge && !disabled &&
        !i_kick_floating && ADJUSTABLE |=>
        state == swdt_pkg::SWDT_NORMAL)
        else $error("first kick did not select normal period");

    a_wdo_kick_high: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        kick_edge && !o_watchdog_expired_n && !disabled
        |=> o_watchdog_expired_n)
        else $error("kick did not return expired output high");

    a_long_after_release: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        $rose(o_reset_n) && !disabled && !i_kick_floating |->
        state == swdt_pkg::SWDT_LONG)
        else $error("release did not restart long period");

    a_expiry_on_tick: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        $fell(o_reset_n) |-> $past(tick))
        else $error("reset pulse began without a tick");

    a_backup_idle: assert property (@(posedge i_mclk)
        disable iff (!i_rst_b)
        i_backup_battery_level |=> cnt == '0 &&
        state == swdt_pkg::SWDT_LONG)
        else $error("backup did not hold timer idle");

    // Main scenarios reached
    c_timeout: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        $fell(o_reset_n));
    c_release: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_reset_n));
    c_normal: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        state == swdt_pkg::SWDT_NORMAL);
    c_float_idle: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_kick_floating && kick_edge);
    c_wdo_cleared: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_watchdog_expired_n));
endmodule

// >>> swdt_cpu_model.sv
// Processor model that toggles the watchdog kick pin
`timescale 1ns/10ps
module swdt_cpu_model
(
    input  wire logic        i_mclk,
    input  wire logic        i_run,
    input  wire logic        i_float,
    input  wire logic [15:0] i_gap,
    output logic             o_kick
);
    int cnt = 0;  // Clocks since last toggle
    initial o_kick = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Toggle once per gap; an open pin flickers every clock
    always @(negedge i_mclk)
    begin
        if (i_float)
        begin
            o_kick <= ~o_kick;
            cnt    <= 0;
        end
        else if (i_run && cnt >= int'(i_gap))
        begin
            o_kick <= ~o_kick;
            cnt    <= 0;
        end
        else
            cnt <= i_run ? cnt + 1 : 0;
    end
endmodule

// >>> tb_top.sv
// Self-checking bench for the supervisor watchdog timer
`timescale 1ns/10ps
module tb_top;
    logic        i_mclk;      // 20 MHz clock
    logic        i_rst_b;     // Async reset, low active
    logic        kick;        // Kick pin from the model
    logic        kick_float;  // Kick pin left open
    logic        tb_in = 1'b0; // External tick pin
    logic        clock_source_select;     // Clock source select pin
    logic        sel_float;   // Select pin left open
    logic        supply_low;  // Supply below threshold
    logic        batt;        // Battery backup active
    logic        reset_n;     // Reset output
    logic        expired_n;   // Expired output
    logic        run;         // Model kicks while high
    logic [15:0] gap;         // Model kick spacing in clocks
    int          err_count;   // Mismatches
    int          num_checks;  // Comparisons
    int          cyc = 0;     // Clock cycles run
    int          n;           // Measured clocks
    ////////////////////////////////////////////////////////////////////////
    // Design and processor model
    swdt_top swdt_top_i
    (
        .i_mclk(i_mclk),                 .i_rst_b(i_rst_b),
        .i_watchdog_kick_in(kick),       .i_kick_floating(kick_float),
        .i_clock_source_select(clock_source_select), .i_sel_floating(sel_float),
        .i_timebase_input(tb_in),        .i_timebase_floating(1'b0),
        .i_supply_low(supply_low),       .i_backup_battery_level(batt),
        .o_reset_n(reset_n),             .o_watchdog_expired_n(expired_n)
    );
    swdt_cpu_model swdt_cpu_model_i
    (
        .i_mclk(i_mclk), .i_run(run), .i_float(kick_float),
        .i_gap(gap),     .o_kick(kick)
    );
    ////////////////////////////////////////////////////////////////////////
    // Clock, external tick every two clocks, hang limit
    initial
    begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    always @(negedge i_mclk)
        tb_in <= ~tb_in;
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            err_count++;
            $display("wrong value at %0t: run too long", $time);
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Shared checks and waits
    function automatic int exp_clks(input logic [15:0] t);
        return 2 * int'(t) + 2;  // Two clocks a tick plus sync delay
    endfunction
    task automatic check_bit(input logic got, input logic exp, string what);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic check_span(input int got, input int exp, string what);
        num_checks++;
        if (got < exp - 8 || got > exp + 8)
        begin
            err_count++;
            $display("wrong value at %0t: %s %0d", $time, what, got);
        end
    endtask
    task automatic wait_rst(input logic lvl, input int lim, output int clks);
        clks = 0;
        while (reset_n !== lvl && clks < lim)
        begin
            @(negedge i_mclk);
            clks++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        i_rst_b    = 1'b0;
        run        = 1'b0;
        gap        = 16'h0400;
        kick_float = 1'b0;
        clock_source_select    = 1'b0;
        sel_float  = 1'b0;
        supply_low = 1'b0;
        batt       = 1'b0;
        err_count  = 0;
        num_checks = 0;
        void'($urandom(32'h6fc9));
        repeat (6) @(negedge i_mclk);
        i_rst_b = 1'b1;
        // Silent processor: long period, then repeated pulses
        for (int k = 0; k < 2; k++)
        begin
            wait_rst(1'b0, 20000, n);
            check_span(n, exp_clks(swdt_pkg::LONG_CLKS), "long");
            check_bit(expired_n, 1'b0, "expired not low");
            wait_rst(1'b1, 3000, n);
            check_span(n, exp_clks(swdt_pkg::RST_SHORT_CLKS), "width");
        end
        $display("test silent done");
        // Random kick spacing; one polarity alone would be too slow
        run = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            gap = 16'(1100 + $urandom % 800);
            wait_rst(1'b0, 2000, n);
            check_bit(reset_n, 1'b1, "reset while kicked");
        end
        check_bit(expired_n, 1'b1, "expired not cleared");
        $display("test kicked done");
        // Stop right after a kick: short period now applies
        @(kick);
        run = 1'b0;
        wait_rst(1'b0, 4000, n);
        check_span(n, exp_clks(swdt_pkg::NORM_CLKS), "short");
        wait_rst(1'b1, 3000, n);
        $display("test short done");
        // Each disable source: no resets; expired output high for supply fail and backup
        for (int k = 0; k < 3; k++)
        begin
            if (k == 1)
            begin
                // Fresh short timeout so the next force is seen
                supply_low = 1'b0;
                run        = 1'b1;
                @(kick);
                run        = 1'b0;
                wait_rst(1'b0, 4000, n);
                check_bit(expired_n, 1'b0, "expired not low");
                wait_rst(1'b1, 3000, n);
            end
            supply_low = (k == 0);
            batt       = (k == 1);
            kick_float = (k == 2);
            repeat (4) @(negedge i_mclk);
            if (k < 2)
                check_bit(expired_n, 1'b1, "expired not high");
            wait_rst(1'b0, 8400, n);
            check_bit(reset_n, 1'b1, "reset while disabled");
        end
        kick_float = 1'b0;
        $display("test disable done");
        // Internal base ticks far slower: no timeout in this window
        for (int k = 0; k < 2; k++)
        begin
            clock_source_select   = (k == 0);
            sel_float = (k == 1);
            wait_rst(1'b0, 8400, n);
            check_bit(reset_n, 1'b1, "internal too fast");
        end
        $display("test internal done");
        tally_and_finish();
    end
endmodule
